// file: hw/ubg_consts.vh
// Purpose: Constants of the serial port baud rate generator
// Assumes: APB byte addresses, 32-bit words
// Notes:   Offsets and reset values are named once here
`ifndef UBG_CONSTS_VH
`define UBG_CONSTS_VH
`define UBG_OFS_MODE      12'h000
`define UBG_OFS_CLKSEL    12'h004
`define UBG_OFS_DIVISOR   12'h008
`define UBG_OFS_STATUS    12'h00c
`define UBG_OFS_EVENT     12'h010
`define UBG_BIT_POWER     7
`define UBG_BIT_TXE       6
`define UBG_BIT_RXE       5
`define UBG_RST_MODE      8'h00
`define UBG_RST_CLKSEL    8'h00
`define UBG_RST_DIVISOR   8'hff
`define UBG_SEL_TIMER     4'hb
`define UBG_SEL_MAXDIV    4'ha
`define UBG_K_MIN         8'h08
`define UBG_LATCH_MARGIN  2
`endif

// file: hw/ubg_top.v
// Purpose: Baud rate generator with transmit and receive bit-rate counters
// Assumes: core_clk 50 MHz; base clock realised as a one-cycle enable
// Notes:   Registers reached over APB; receive line sampled through 3 flops
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.vh"

module ubg_top #(
    parameter FRAME_BITS = 11
) (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rx_line,
    input  wire        timer_out,
    input  wire        tx_data_pending,
    output reg         base_clk_out,
    output reg         tx_bit_tick,
    output reg         tx_frame_done,
    output reg         rx_latch_tick,
    output reg         rx_frame_done
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    // Release is synchronous, so no flop leaves reset a cycle apart from the rest
    reg rst_meta_r;
    reg rst_n_r;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [7:0]  mode_r;
    reg  [7:0]  clksel_r;
    reg  [7:0]  divisor_r;
    reg         txb_write_r;
    reg         event_r;
    // Counter states are declared here because the read mux looks at them
    reg  [7:0]  tx_cnt_r;
    reg  [7:0]  rx_cnt_r;
    reg         rx_busy_r;
    wire        power   = mode_r[`UBG_BIT_POWER];
    wire        tx_run  = power & mode_r[`UBG_BIT_TXE];
    wire        rx_run  = power & mode_r[`UBG_BIT_RXE];
    wire        access  = psel & penable;
    wire        wr_acc  = access & pwrite;
    wire        hit     = (paddr == `UBG_OFS_MODE) || (paddr == `UBG_OFS_CLKSEL) ||
                          (paddr == `UBG_OFS_DIVISOR) || (paddr == `UBG_OFS_STATUS) ||
                          (paddr == `UBG_OFS_EVENT);
    wire [7:0]  k_val   = divisor_r;

    // Zero-wait slave: answers in the first access cycle
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r      <= `UBG_RST_MODE;
            clksel_r    <= `UBG_RST_CLKSEL;
            divisor_r   <= `UBG_RST_DIVISOR;
            txb_write_r <= 1'b0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0000_0000;
        end else begin
            pready      <= psel & ~penable;
            pslverr     <= psel & ~penable & ~hit;
            txb_write_r <= 1'b0;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `UBG_OFS_MODE:    prdata <= {24'h000000, mode_r};
                    `UBG_OFS_CLKSEL:  prdata <= {24'h000000, clksel_r};
                    `UBG_OFS_DIVISOR: prdata <= {24'h000000, divisor_r};
                    `UBG_OFS_STATUS:  prdata <= {24'h000000, tx_cnt_r};
                    `UBG_OFS_EVENT:   prdata <= {22'h000000, rx_cnt_r, rx_busy_r, event_r};
                    default:          prdata <= 32'h0000_0000;
                endcase
            end
            if (wr_acc & pready) begin
                case (paddr)
                    `UBG_OFS_MODE:    mode_r    <= pwdata[7:0];
                    `UBG_OFS_CLKSEL:  clksel_r  <= {4'h0, pwdata[3:0]};
                    `UBG_OFS_DIVISOR: divisor_r <= pwdata[7:0];
                    // Writing here stands for a transmit buffer load
                    `UBG_OFS_EVENT:   txb_write_r <= 1'b1;
                    default:          ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: free 10-bit divider, one-cycle enable per selected period
    // One counter serves every divided select, so a new select takes effect at once
    // Timer output comes from logic on core_clk, so only its edge is taken
    reg  [9:0]  presc_r;
    reg         timer_q_r;
    reg         base_en;
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            presc_r   <= 10'h000;
            timer_q_r <= 1'b0;
        end else begin
            presc_r   <= presc_r + 10'h001;
            timer_q_r <= timer_out;
        end
    end

    always @* begin
        base_en = 1'b0;
        if (power) begin
            if (clksel_r[3:0] == `UBG_SEL_TIMER)
                base_en = timer_out & ~timer_q_r;
            else if (clksel_r[3:0] == 4'h0)
                base_en = 1'b1;
            else if (clksel_r[3:0] <= `UBG_SEL_MAXDIV)
                base_en = (presc_r & ((10'h001 << clksel_r[3:0]) - 10'h001)) == 10'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive line: three flops, change taken once second and third agree
    // Line idles high, so the flops reset high and no false start follows reset
    reg  [2:0]  rx_sync_r;
    reg         rx_filt_r;
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_sync_r <= 3'b111;
            rx_filt_r <= 1'b1;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rx_line};
            if (rx_sync_r[1] == rx_sync_r[2])
                rx_filt_r <= rx_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter step: wraps at k, reports the wrap
    // A divisor lowered mid-count wraps at once rather than running on to 255;
    // the bit in flight is then short, a limitation software must allow for
    function [8:0] ubg_step;
        input [7:0] cnt;
        input [7:0] k;
        begin
            if (cnt + 8'h01 >= k)
                ubg_step = {1'b1, 8'h00};
            else
                ubg_step = {1'b0, cnt + 8'h01};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // transmit counter, independent of receive
    reg         tx_half_r;
    reg  [3:0]  tx_bit_r;
    reg         tx_active_r;
    reg  [8:0]  tx_s;
    always @* tx_s = ubg_step(tx_cnt_r, k_val);

    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_cnt_r      <= 8'h00;
            tx_half_r     <= 1'b0;
            tx_bit_r      <= 4'h0;
            tx_active_r   <= 1'b0;
            tx_bit_tick   <= 1'b0;
            tx_frame_done <= 1'b0;
        end else begin
            tx_bit_tick   <= 1'b0;
            tx_frame_done <= 1'b0;
            if (!tx_run) begin
                tx_cnt_r    <= 8'h00;
                tx_half_r   <= 1'b0;
                tx_bit_r    <= 4'h0;
                tx_active_r <= 1'b0;
            end else if (txb_write_r && !tx_active_r) begin
                tx_cnt_r    <= 8'h00;
                tx_half_r   <= 1'b0;
                tx_bit_r    <= 4'h0;
                tx_active_r <= 1'b1;
            end else if (base_en) begin
                tx_cnt_r <= tx_s[7:0];
                if (tx_s[8]) begin
                    tx_half_r <= ~tx_half_r;
                    if (tx_half_r) begin
                        tx_bit_tick <= 1'b1;
                        if (tx_active_r && tx_bit_r == FRAME_BITS[3:0] - 4'h1) begin
                            tx_frame_done <= 1'b1;
                            tx_bit_r      <= 4'h0;
                            // reclear on next frame, else run on
                            tx_active_r   <= tx_data_pending;
                            if (tx_data_pending) begin
                                tx_cnt_r  <= 8'h00;
                                tx_half_r <= 1'b0;
                            end
                        end else if (tx_active_r) begin
                            tx_bit_r <= tx_bit_r + 4'h1;
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive counter, started by start bit, halts after one frame
    reg         rx_half_r;
    reg  [3:0]  rx_bit_r;
    reg  [8:0]  rx_s;
    always @* rx_s = ubg_step(rx_cnt_r, k_val);

    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_cnt_r      <= 8'h00;
            rx_half_r     <= 1'b0;
            rx_bit_r      <= 4'h0;
            rx_busy_r     <= 1'b0;
            rx_latch_tick <= 1'b0;
            rx_frame_done <= 1'b0;
        end else begin
            rx_latch_tick <= 1'b0;
            rx_frame_done <= 1'b0;
            if (!rx_run) begin
                rx_cnt_r  <= 8'h00;
                rx_half_r <= 1'b0;
                rx_bit_r  <= 4'h0;
                rx_busy_r <= 1'b0;
            end else if (!rx_busy_r) begin
                rx_cnt_r  <= 8'h00;
                rx_half_r <= 1'b0;
                rx_bit_r  <= 4'h0;
                rx_busy_r <= ~rx_filt_r;
            end else if (base_en) begin
                rx_cnt_r <= rx_s[7:0];
                if (rx_s[8]) begin
                    rx_half_r <= ~rx_half_r;
                    // latch at mid-bit, first half of each 2k period
                    // two-clock margin lies in the filter delay
                    if (!rx_half_r) begin
                        rx_latch_tick <= 1'b1;
                        if (rx_bit_r == FRAME_BITS[3:0] - 4'h1) begin
                            rx_frame_done <= 1'b1;
                            rx_busy_r     <= 1'b0;
                        end
                        rx_bit_r <= rx_bit_r + 4'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky record of receive frame ends, set wins over the write clear
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            event_r      <= 1'b0;
            base_clk_out <= 1'b0;
        end else begin
            base_clk_out <= base_en;
            event_r      <= rx_frame_done | (event_r &
                            ~(wr_acc & pready & (paddr == `UBG_OFS_STATUS)));
        end
    end

endmodule
`default_nettype wire

// file: testbench/tb_uart_baud_rate_generator.sv
// Purpose: Self-checking bench for the baud rate generator
// Assumes: 50 MHz core clock; APB answers in the first access cycle
// Notes:   Output pulses are counted over fixed windows
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.vh"
module tb_uart_baud_rate_generator;
    logic        core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rx_line, timer_out = 1'b0, tx_pend = 1'b0;
    logic        base_clk_out, tx_bit_tick, tx_frame_done, rx_latch_tick, rx_frame_done;
    logic [15:0] seed = 16'd51138;
    logic [32:0] exp_q[$];
    int          failures = 0, compares = 0, cyc = 0, n_base = 0, n_tx = 0, n_txf = 0;
    int          n_rx = 0, n_rxf = 0, tx_last = 0, tx_gap = 0, n_trise = 0;
    logic        t_prev = 1'b0, t_rise = 1'b0;
    always #10 core_clk = ~core_clk;
    ubg_top ubg_top_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_line(rx_line), .timer_out(timer_out), .tx_data_pending(tx_pend),
        .base_clk_out(base_clk_out), .tx_bit_tick(tx_bit_tick), .tx_frame_done(tx_frame_done),
        .rx_latch_tick(rx_latch_tick), .rx_frame_done(rx_frame_done));
    ubg_remote_tx ubg_remote_tx_i (.core_clk(core_clk), .base_tick(base_clk_out), .rx_line(rx_line));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] xs(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        x ^= x << 8;
        return x;
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        compares++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Pulse counters; the timer input toggles randomly so its path is exercised
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        n_base <= n_base + base_clk_out;
        n_tx <= n_tx + tx_bit_tick;
        n_txf <= n_txf + tx_frame_done;
        n_rx <= n_rx + rx_latch_tick;
        n_rxf <= n_rxf + rx_frame_done;
        if (tx_bit_tick === 1'b1) begin
            tx_gap <= cyc - tx_last;
            tx_last <= cyc;
        end
        seed <= xs(seed);
        timer_out <= seed[0];
        // Rising edges of the timer input, lined up with the base clock output
        t_prev <= timer_out;
        t_rise <= timer_out & ~t_prev;
        n_trise <= n_trise + t_rise;
    end
    // Oldest noted read result is compared when a read completes
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff);
    // Release one edge after the answer so psel is never set twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        t = 0;
        do begin @(posedge core_clk); t++; end while (pready !== 1'b1 && t < 50);
        if (t >= 50) begin failures++; finish_test(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic e);
        exp_q.push_back({e, v});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic tx_run(input int k);
        int b, t;
        b = n_txf;
        apb(1'b1, `UBG_OFS_EVENT, {24'h0, seed[7:0]});
        // Skip the edge that may still carry a free-running tick from before the load
        @(posedge core_clk);
        t = n_tx;
        for (int j = 0; j < 30 * k && n_txf == b; j++) @(posedge core_clk);
        check(n_txf - b, 1);
        if (n_txf == b) finish_test();
        check(n_tx - t, 11);
        check(tx_gap, 2 * k);
    endtask
    initial begin
        int b, r, rf;
        logic [7:0] kv;
        logic [7:0] ks [3];
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`UBG_OFS_MODE, 32'h0, 1'b0);
        rd(`UBG_OFS_CLKSEL, 32'h0, 1'b0);
        rd(`UBG_OFS_DIVISOR, 32'hff, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        kv = 8'h08 + 8'(seed % 16'd248);
        ks = '{8'd8, kv, 8'd129};
        apb(1'b1, `UBG_OFS_DIVISOR, {24'h0, kv});
        rd(`UBG_OFS_DIVISOR, {24'h0, kv}, 1'b0);
        apb(1'b1, `UBG_OFS_MODE, 32'h80);
        // Two settling edges keep the old setting's last pulse out of each window
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, `UBG_OFS_CLKSEL, n);
            repeat (2) @(posedge core_clk);
            b = n_base;
            repeat (256) @(posedge core_clk);
            check(n_base - b, 256 >> n);
        end
        // Timer select: one base clock per rising edge of the timer input
        apb(1'b1, `UBG_OFS_CLKSEL, {28'h0, `UBG_SEL_TIMER});
        repeat (2) @(posedge core_clk);
        b = n_base;
        r = n_trise;
        repeat (256) @(posedge core_clk);
        check(n_base - b, n_trise - r);
        // Bit timing below assumes one base clock per core clock
        apb(1'b1, `UBG_OFS_CLKSEL, 32'h0);
        apb(1'b1, `UBG_OFS_MODE, 32'h0);
        repeat (2) @(posedge core_clk);
        b = n_base;
        repeat (100) @(posedge core_clk);
        check(n_base - b, 0);
        apb(1'b1, `UBG_OFS_MODE, 32'hc0);
        foreach (ks[i]) begin
            apb(1'b1, `UBG_OFS_DIVISOR, {24'h0, ks[i]});
            tx_run(ks[i]);
        end
        // A pending character runs the next frame on; without one the count runs free
        tx_pend <= 1'b1;
        tx_run(129);
        tx_pend <= 1'b0;
        b = n_txf;
        r = n_tx;
        for (int j = 0; j < 3870 && n_txf == b; j++) @(posedge core_clk);
        check(n_txf - b, 1);
        if (n_txf == b) finish_test();
        check(n_tx - r, 11);
        r = n_tx;
        repeat (387) @(posedge core_clk);
        check(n_tx - r, 1);
        apb(1'b1, `UBG_OFS_MODE, 32'h80);
        repeat (2) @(posedge core_clk);
        b = n_tx;
        repeat (100) @(posedge core_clk);
        check(n_tx - b, 0);
        rd(`UBG_OFS_STATUS, 32'h0, 1'b0);
        apb(1'b1, `UBG_OFS_DIVISOR, 32'h0c);
        apb(1'b1, `UBG_OFS_MODE, 32'he0);
        r = n_rx;
        repeat (200) @(posedge core_clk);
        check(n_rx - r, 0);
        rf = n_rxf;
        fork
            ubg_remote_tx_i.send(seed[7:0], 12);
            tx_run(12);
        join
        check(n_rx - r, 11);
        check(n_rxf - rf, 1);
        r = n_rx;
        repeat (300) @(posedge core_clk);
        check(n_rx - r, 0);
        rd(`UBG_OFS_EVENT, 32'h1, 1'b0);
        apb(1'b1, `UBG_OFS_STATUS, 32'h0);
        apb(1'b1, `UBG_OFS_MODE, 32'hc0);
        ubg_remote_tx_i.send(8'h3c, 12);
        check(n_rx - r, 0);
        rd(`UBG_OFS_EVENT, 32'h0, 1'b0);
        finish_test();
    end
endmodule
bind ubg_top ubg_monitor ubg_monitor_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .base_clk_out(base_clk_out), .tx_bit_tick(tx_bit_tick),
    .rx_latch_tick(rx_latch_tick), .rx_frame_done(rx_frame_done));
`default_nettype wire

// file: testbench/ubg_monitor.sv
// Purpose: Port checker for the baud rate generator
// Assumes: A write lands at the edge where pready is sampled
// Notes:   Mode bits are mirrored from observed writes
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.vh"
module ubg_monitor (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        base_clk_out,
    input wire logic        tx_bit_tick,
    input wire logic        rx_latch_tick,
    input wire logic        rx_frame_done
);
    logic [2:0] mode_r; // Power, transmit, receive
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    // Mirror of the mode register; three cycles of slack cover registered outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            mode_r <= 3'h0;
        else if (psel && penable && pready && pwrite && paddr == `UBG_OFS_MODE)
            mode_r <= pwdata[7:5];
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    chk_base_low: assert property ((!mode_r[2]) [*3] |-> !base_clk_out)
        else $error("base clock pulse with power off");
    chk_tx_held: assert property ((!(mode_r[2] && mode_r[1])) [*3] |-> !tx_bit_tick)
        else $error("transmit tick while disabled");
    chk_rx_held: assert property ((!(mode_r[2] && mode_r[0])) [*3] |-> !rx_latch_tick)
        else $error("receive latch while disabled");
    chk_tx_spacing: assert property (tx_bit_tick |=> !tx_bit_tick [*8])
        else $error("transmit bits too close");
    chk_rx_spacing: assert property (rx_latch_tick |=> !rx_latch_tick [*8])
        else $error("receive latches too close");
    chk_rx_last: assert property (rx_frame_done |-> rx_latch_tick)
        else $error("frame end without last latch");
    chk_ready_pulse: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
    chk_unmapped_err: assert property (psel && penable && pready && paddr > `UBG_OFS_EVENT |-> pslverr)
        else $error("unmapped access without error");
endmodule
`default_nettype wire

// file: testbench/ubg_remote_tx.sv
// Purpose: Remote serial transmitter driving the receive line
// Assumes: Shares base clock and divisor with the local side
// Notes:   Frame is start, 8 data LSB first, parity, stop
`timescale 1ns/1ps
`default_nettype none
module ubg_remote_tx (
    input  wire logic core_clk,
    input  wire logic base_tick,
    output var  logic rx_line
);
    initial rx_line = 1'b1;
    // One bit spans 2k base ticks; bounded so a stopped base clock cannot hang
    task automatic hold_bit(input logic b, input int k);
        int n;
        n = 0;
        rx_line <= b;
        for (int j = 0; j < 600 * k && n < 2 * k; j++) begin
            @(posedge core_clk);
            n += int'(base_tick);
        end
    endtask
    task automatic send(input logic [7:0] d, input int k);
        logic [10:0] f;
        f = {1'b1, ^d, d, 1'b0};
        for (int i = 0; i < 11; i++)
            hold_bit(f[i], k);
    endtask
endmodule
`default_nettype wire
